// [cop_exec_pkg.sv]
// Purpose: shared constants and carriers for the coprocessor move and doubleword add unit
// Assumes: 32-bit instruction words, 64-bit general registers
// Notes:   field positions and opcodes are named once here
package cop_exec_pkg;

  localparam int unsigned OPC_HI      = 31;
  localparam int unsigned OPC_LO      = 26;
  localparam int unsigned SRC_HI      = 25;
  localparam int unsigned SRC_LO      = 21;
  localparam int unsigned TGT_HI      = 20;
  localparam int unsigned TGT_LO      = 16;
  localparam int unsigned DST_HI      = 15;
  localparam int unsigned DST_LO      = 11;
  localparam int unsigned SHF_HI      = 10;
  localparam int unsigned SHF_LO      = 6;
  localparam int unsigned FN_HI       = 5;
  localparam int unsigned FN_LO       = 0;
  localparam int unsigned IMM_HI      = 15;
  localparam int unsigned CO_BIT      = 25;
  localparam int unsigned COFUN_HI    = 24;
  localparam int unsigned LOW11_HI    = 10;
  localparam int unsigned SIGN32_BIT  = 31;
  localparam int unsigned CPNUM_HI    = 27;
  localparam int unsigned CPNUM_LO    = 26;

  localparam logic [5:0] OPC_SPECIAL  = 6'h00;
  localparam logic [5:0] OPC_CACHE    = 6'h2f;
  localparam logic [5:0] OPC_ADDI_D   = 6'h18;
  localparam logic [5:0] OPC_ADDIU_D  = 6'h19;
  localparam logic [3:0] OPC_COP_TOP  = 4'h4;
  localparam logic [5:0] FN_ADD_D     = 6'h2c;
  localparam logic [5:0] FN_ADDU_D    = 6'h2d;
  localparam logic [4:0] SUB_CF       = 5'h02;
  localparam logic [4:0] SUB_CT       = 5'h06;
  localparam logic [1:0] CP_SYS       = 2'h0;
  localparam logic [1:0] CP_FLOAT     = 2'h1;

  typedef enum logic [1:0] {
    MODE_USER  = 2'b10,
    MODE_SUPER = 2'b01,
    MODE_KERN  = 2'b00
  } priv_mode_e;

  typedef struct packed {
    logic cop_unusable;
    logic tlb_invalid;
    logic tlb_miss;
    logic bus_error;
    logic addr_error;
    logic reserved_instr;
    logic int_overflow;
    logic float_exc;
  } exc_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  unit;
    logic [4:0]  reg_sel;
    logic [24:0] cofun;
    logic        is_op;
    logic [31:0] data;
  } cop_req_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [63:0] data;
  } gpr_wr_s;

endpackage : cop_exec_pkg

// [dword_adder.sv]
// Purpose: 64-bit adder with two's complement overflow from carries of bits 62 and 63
// Assumes: purely combinational, same clock domain as the caller
// Notes:   overflow is raw; the caller decides whether it traps
module dword_adder
  import cop_exec_pkg::*;
(
  input  wire logic [63:0] a,
  input  wire logic [63:0] b,
  output logic      [63:0] sum,
  output logic             ovf
);
  logic [62:0] low;
  logic        c62;
  logic        c63;

  always_comb begin
    {c62, low} = {1'b0, a[62:0]} + {1'b0, b[62:0]};
    {c63, sum[63]} = {1'b0, a[63]} + {1'b0, b[63]} + {1'b0, c62};
    sum[62:0] = low;
    ovf = c62 ^ c63;
  end
endmodule : dword_adder

// [cop_dword_exec.sv]
// Purpose: execute cache address step, coprocessor control moves, coprocessor ops, dword adds
// Assumes: operands are read by the pipeline and given with the instruction in cycle T
// Notes:   results are registered; a cop read answers in the following cycle
// How it works
// - cache op forms base plus offset address, translates it, then issues the operation
// - cache op reports unusable, tlb invalid, tlb miss, bus and address errors
// - move from coproc reads control register in T+1, writes general register in T+2
// - move to coproc takes target register in T, coproc writes it in T+1
// - control moves undefined for coprocessor zero; unusable raised when unit disabled
// - coproc operation hands the 25-bit function field to the selected unit
// - coproc operation writes no general register, cache or memory
// - coproc operation unusable when disabled; float exception only from unit one
// - signed register add is 64-bit, overflow when carries 62 and 63 differ
// - signed register add overflow suppresses the destination write
// - dword adds run in 64-bit or kernel mode, else reserved instruction
// - immediate adds sign extend bit 15 to 64 bits and write target
// - signed immediate add traps on overflow and keeps target unchanged
// - unsigned immediate add gives same sum, never overflows
// - unsigned register add writes sum to destination, never overflows
module cop_dword_exec
  import cop_exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr,
  input  wire logic [63:0] src_value,
  input  wire logic [63:0] tgt_value,
  input  wire logic        mode_64,
  input  wire priv_mode_e  priv_mode,
  input  wire logic [3:0]  cop_enable,
  input  wire logic [31:0] cop_rd_data,
  input  wire logic        cop_float_exc,
  input  wire logic [35:0] xlate_paddr,
  input  wire logic        xlate_uncached,
  input  wire logic        xlate_done,
  input  wire logic        xlate_tlb_invalid,
  input  wire logic        xlate_tlb_miss,
  input  wire logic        xlate_addr_error,
  input  wire logic        cache_bus_error,
  output cop_req_s         cop_req,
  output logic             xlate_req,
  output logic [63:0]      xlate_vaddr,
  output logic             cache_op_req,
  output logic [4:0]       cache_op_code,
  output logic [63:0]      cache_op_vaddr,
  output logic [35:0]      cache_op_paddr,
  output gpr_wr_s          gpr_wr,
  output exc_s             exc,
  output logic             undefined
);
  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [1:0]  unit;
  logic [4:0]  sub;
  logic        is_cop;
  logic        is_cf;
  logic        is_ct;
  logic        is_op;
  logic        is_add;
  logic        is_addu;
  logic        is_addi;
  logic        is_addiu;
  logic        is_cache;
  logic        dword_ok;
  logic        unit_on;
  logic        zero_ok;
  logic [63:0] imm_ext;
  logic [63:0] add_b;
  logic [63:0] sum;
  logic        ovf;

  cop_req_s    cop_req_reg,    cop_req_next;
  logic        cf_pend_reg,    cf_pend_next;
  logic [4:0]  cf_idx_reg,     cf_idx_next;
  logic        xlate_req_reg,  xlate_req_next;
  logic [63:0] vaddr_reg,      vaddr_next;
  logic [4:0]  cop_code_reg,   cop_code_next;
  logic        cache_req_reg,  cache_req_next;
  logic [35:0] paddr_reg,      paddr_next;
  gpr_wr_s     gpr_wr_reg,     gpr_wr_next;
  exc_s        exc_reg,        exc_next;
  logic        undef_reg,      undef_next;

  dword_adder u_add (
    .a   (src_value),
    .b   (add_b),
    .sum (sum),
    .ovf (ovf)
  );

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  always_comb begin
    opc      = instr[OPC_HI:OPC_LO];
    fn       = instr[FN_HI:FN_LO];
    unit     = instr[CPNUM_HI:CPNUM_LO];
    sub      = instr[SRC_HI:SRC_LO];
    is_cop   = instr_valid && (opc[5:2] == OPC_COP_TOP);
    is_op    = is_cop && instr[CO_BIT];
    is_cf    = is_cop && !instr[CO_BIT] && (sub == SUB_CF);
    is_ct    = is_cop && !instr[CO_BIT] && (sub == SUB_CT);
    is_add   = instr_valid && (opc == OPC_SPECIAL) && (fn == FN_ADD_D);
    is_addu  = instr_valid && (opc == OPC_SPECIAL) && (fn == FN_ADDU_D);
    is_addi  = instr_valid && (opc == OPC_ADDI_D);
    is_addiu = instr_valid && (opc == OPC_ADDIU_D);
    is_cache = instr_valid && (opc == OPC_CACHE);
    dword_ok = mode_64 || (priv_mode == MODE_KERN);
    unit_on  = cop_enable[unit];
    imm_ext  = {{48{instr[IMM_HI]}}, instr[IMM_HI:0]};
    add_b    = (is_addi || is_addiu || is_cache) ? imm_ext : tgt_value;
    zero_ok  = 1'b1;
    if ((is_cf || is_ct) && (instr[LOW11_HI:0] != '0)) begin
      zero_ok = 1'b0;
    end
    if ((is_add || is_addu) && (instr[SHF_HI:SHF_LO] != '0)) begin
      zero_ok = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // execute
  // --------------------------------------------------------------------------
  always_comb begin
    cop_req_next   = '0;
    cf_pend_next   = 1'b0;
    cf_idx_next    = cf_idx_reg;
    xlate_req_next = 1'b0;
    vaddr_next     = vaddr_reg;
    cop_code_next  = cop_code_reg;
    cache_req_next = 1'b0;
    paddr_next     = paddr_reg;
    gpr_wr_next    = '0;
    exc_next       = '0;
    undef_next     = 1'b0;

    // coprocessor read answer lands one cycle later
    if (cf_pend_reg) begin
      gpr_wr_next.valid = 1'b1;
      gpr_wr_next.idx   = cf_idx_reg;
      gpr_wr_next.data  = mode_64 ? {{32{cop_rd_data[SIGN32_BIT]}}, cop_rd_data}
                                  : {32'h0000_0000, cop_rd_data};
    end

    // translation result completes the cache operation
    if (xlate_done) begin
      exc_next.tlb_invalid = xlate_tlb_invalid;
      exc_next.tlb_miss    = xlate_tlb_miss;
      exc_next.addr_error  = xlate_addr_error;
      if (!(xlate_tlb_invalid || xlate_tlb_miss || xlate_addr_error)) begin
        cache_req_next = 1'b1;
        paddr_next     = xlate_paddr;
      end
    end
    exc_next.bus_error = cache_bus_error;

    if (!zero_ok) begin
      undef_next = 1'b1;
    end else if (is_cf || is_ct) begin
      if (unit == CP_SYS) begin
        undef_next = 1'b1;
      end else if (!unit_on) begin
        exc_next.cop_unusable = 1'b1;
      end else begin
        cop_req_next.valid   = 1'b1;
        cop_req_next.write   = is_ct;
        cop_req_next.unit    = unit;
        cop_req_next.reg_sel = instr[DST_HI:DST_LO];
        cop_req_next.data    = tgt_value[31:0];
        cf_pend_next         = is_cf;
        cf_idx_next          = instr[TGT_HI:TGT_LO];
      end
    end else if (is_op) begin
      if (!unit_on) begin
        exc_next.cop_unusable = 1'b1;
      end else begin
        cop_req_next.valid = 1'b1;
        cop_req_next.is_op = 1'b1;
        cop_req_next.unit  = unit;
        cop_req_next.cofun = instr[COFUN_HI:0];
      end
    end else if (is_add || is_addu || is_addi || is_addiu) begin
      if (!dword_ok) begin
        exc_next.reserved_instr = 1'b1;
      end else if ((is_add || is_addi) && ovf) begin
        exc_next.int_overflow = 1'b1;
      end else begin
        gpr_wr_next.valid = 1'b1;
        gpr_wr_next.idx   = (is_add || is_addu) ? instr[DST_HI:DST_LO]
                                                : instr[TGT_HI:TGT_LO];
        gpr_wr_next.data  = sum;
      end
    end else if (is_cache) begin
      if (!cop_enable[CP_SYS] && (priv_mode != MODE_KERN)) begin
        exc_next.cop_unusable = 1'b1;
      end else begin
        xlate_req_next = 1'b1;
        vaddr_next     = sum;
        cop_code_next  = instr[TGT_HI:TGT_LO];
      end
    end

    // float exception reported only for unit one
    if (cop_float_exc && (cop_req_reg.unit == CP_FLOAT) && cop_req_reg.is_op) begin
      exc_next.float_exc = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cop_req_reg   <= '0;
      cf_pend_reg   <= 1'b0;
      cf_idx_reg    <= '0;
      xlate_req_reg <= 1'b0;
      vaddr_reg     <= '0;
      cop_code_reg  <= '0;
      cache_req_reg <= 1'b0;
      paddr_reg     <= '0;
      gpr_wr_reg    <= '0;
      exc_reg       <= '0;
      undef_reg     <= 1'b0;
    end else begin
      cop_req_reg   <= cop_req_next;
      cf_pend_reg   <= cf_pend_next;
      cf_idx_reg    <= cf_idx_next;
      xlate_req_reg <= xlate_req_next;
      vaddr_reg     <= vaddr_next;
      cop_code_reg  <= cop_code_next;
      cache_req_reg <= cache_req_next;
      paddr_reg     <= paddr_next;
      gpr_wr_reg    <= gpr_wr_next;
      exc_reg       <= exc_next;
      undef_reg     <= undef_next;
    end
  end

  assign cop_req        = cop_req_reg;
  assign xlate_req      = xlate_req_reg;
  assign xlate_vaddr    = vaddr_reg;
  assign cache_op_req   = cache_req_reg;
  assign cache_op_code  = cop_code_reg;
  assign cache_op_vaddr = vaddr_reg;
  assign cache_op_paddr = paddr_reg;
  assign gpr_wr         = gpr_wr_reg;
  assign exc            = exc_reg;
  assign undefined      = undef_reg;
endmodule : cop_dword_exec

// [cop_dword_exec_props.sv]
// Purpose: port checks for cop_dword_exec
// Assumes: one clock, sync active-high reset
// Notes:   bound below the module
module cop_dword_exec_chk
  import cop_exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] src_value,
  input wire logic [63:0] tgt_value,
  input wire logic        mode_64,
  input wire priv_mode_e  priv_mode,
  input wire logic [3:0]  cop_enable,
  input wire logic [31:0] cop_rd_data,
  input wire logic [35:0] xlate_paddr,
  input wire logic        xlate_done,
  input wire logic        xlate_tlb_invalid,
  input wire logic        xlate_tlb_miss,
  input wire logic        xlate_addr_error,
  input wire cop_req_s    cop_req,
  input wire logic        cache_op_req,
  input wire logic [35:0] cache_op_paddr,
  input wire gpr_wr_s     gpr_wr,
  input wire exc_s        exc,
  input wire logic        undefined
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [63:0] s_rr;
  logic [63:0] s_ri;
  logic        ok, sp, ad, adu, ai, aiu, cop, cf, ct, en, o_rr, o_ri, u0;
  assign s_rr = src_value + tgt_value;
  assign s_ri = src_value + {{48{instr[15]}}, instr[15:0]};
  assign ok   = mode_64 || priv_mode == MODE_KERN;
  assign sp   = instr_valid && instr[31:26] == OPC_SPECIAL && instr[10:6] == 5'h0;
  assign ad   = sp && instr[5:0] == FN_ADD_D;
  assign adu  = sp && instr[5:0] == FN_ADDU_D;
  assign ai   = instr_valid && instr[31:26] == OPC_ADDI_D;
  assign aiu  = instr_valid && instr[31:26] == OPC_ADDIU_D;
  assign cop  = instr_valid && instr[31:28] == OPC_COP_TOP;
  assign cf   = cop && instr[25:21] == SUB_CF && instr[10:0] == 11'h0;
  assign ct   = cop && instr[25:21] == SUB_CT && instr[10:0] == 11'h0;
  assign en   = cop_enable[instr[27:26]];
  assign u0   = instr[27:26] == CP_SYS;
  assign o_rr = src_value[63] == tgt_value[63] && s_rr[63] != src_value[63];
  assign o_ri = src_value[63] == instr[15] && s_ri[63] != src_value[63];
  property p_rsum;
    (adu || ad && !o_rr) && ok |=> gpr_wr.valid && gpr_wr.data == $past(s_rr)
      && gpr_wr.idx == $past(instr[15:11]) && !exc.int_overflow;
  endproperty
  a_rsum: assert property (p_rsum) else $error("register add result");
  property p_isum;
    (aiu || ai && !o_ri) && ok |=> gpr_wr.valid && gpr_wr.data == $past(s_ri)
      && gpr_wr.idx == $past(instr[20:16]) && !exc.int_overflow;
  endproperty
  a_isum: assert property (p_isum) else $error("immediate add result");
  property p_ovf;
    ok && (ad && o_rr || ai && o_ri) |=> exc.int_overflow && !gpr_wr.valid;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow handling");
  property p_mode;
    (ad || adu || ai || aiu) && !ok |=> exc.reserved_instr && !gpr_wr.valid;
  endproperty
  a_mode: assert property (p_mode) else $error("mode gate");
  property p_cf;
    cop_req.valid && !cop_req.write && !cop_req.is_op |=> gpr_wr.valid && gpr_wr.data
      == {$past(mode_64) ? {32{$past(cop_rd_data[31])}} : 32'h0, $past(cop_rd_data)};
  endproperty
  a_cf: assert property (p_cf) else $error("move from control");
  property p_ct;
    ct && en && !u0 |=> cop_req.valid && cop_req.write
      && cop_req.reg_sel == $past(instr[15:11]) && cop_req.data == $past(tgt_value[31:0]);
  endproperty
  a_ct: assert property (p_ct) else $error("move to control");
  property p_cp0;
    (cf || ct) && u0 |=> undefined && !cop_req.valid;
  endproperty
  a_cp0: assert property (p_cp0) else $error("unit zero move");
  property p_unus;
    (cf || ct || cop && instr[25]) && !en && !u0 |=> exc.cop_unusable ##0 !cop_req.valid;
  endproperty
  a_unus: assert property (p_unus) else $error("unit disabled");
  property p_op;
    cop && instr[25] && en |=> cop_req.valid && cop_req.is_op
      && cop_req.cofun == $past(instr[24:0]) && !gpr_wr.valid;
  endproperty
  a_op: assert property (p_op) else $error("coproc operation");
  property p_cache;
    xlate_done && !(xlate_tlb_invalid || xlate_tlb_miss || xlate_addr_error)
      |=> cache_op_req && cache_op_paddr == $past(xlate_paddr);
  endproperty
  a_cache: assert property (p_cache) else $error("cache issue");
  c_ovf: cover property (exc.int_overflow);
  c_move: cover property (cop_req.valid && !cop_req.write ##1 gpr_wr.valid);
  c_cache: cover property (cache_op_req);
endmodule : cop_dword_exec_chk

bind cop_dword_exec cop_dword_exec_chk i_chk (.clk, .sys_rst, .instr_valid, .instr,
  .src_value, .tgt_value, .mode_64, .priv_mode, .cop_enable, .cop_rd_data, .xlate_paddr,
  .xlate_done, .xlate_tlb_invalid, .xlate_tlb_miss, .xlate_addr_error, .cop_req,
  .cache_op_req, .cache_op_paddr, .gpr_wr, .exc, .undefined);

// [cop_partner.sv]
// Purpose: attached coprocessor model
// Assumes: read answered while the request shows, held one more cycle
// Notes:   idle read bus shows inverted last value
module cop_partner
  import cop_exec_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     sys_rst,
  input  wire cop_req_s cop_req,
  input  wire logic     fexc_cmd,
  output logic [31:0]   cop_rd_data,
  output logic          cop_float_exc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_reg [4][32];
  logic [31:0] last_reg = 32'h0;
  logic        live_reg = 1'b0;
  logic        rd;
  assign rd = cop_req.valid && !cop_req.write && !cop_req.is_op;
  assign cop_rd_data = rd ? ctrl_reg[cop_req.unit][cop_req.reg_sel]
                     : live_reg ? last_reg : ~last_reg;
  assign cop_float_exc = cop_req.valid && cop_req.is_op && cop_req.unit == CP_FLOAT
                         && fexc_cmd;
  always_ff @(posedge clk) begin
    live_reg <= rd && !sys_rst;
    if (rd) begin
      last_reg <= cop_rd_data;
    end
    if (cop_req.valid && cop_req.write) begin
      ctrl_reg[cop_req.unit][cop_req.reg_sel] <= cop_req.data;
    end
  end
endmodule : cop_partner

// [tb_cop_dword_exec.sv]
// Purpose: directed bench for cop_dword_exec
// Assumes: inputs change on falling edge
// Notes:   one task per scenario
module tb_cop_dword_exec
  import cop_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, sys_rst = 1, instr_valid = 0, mode_64 = 1, xlate_done = 0;
  logic        xlate_tlb_miss = 0, cache_bus_error = 0, fexc_cmd = 0, xlate_uncached = 0;
  logic        xlate_tlb_invalid = 0, xlate_addr_error = 0;
  logic [31:0] instr = 0, cop_rd_data;
  logic [63:0] src_value = 0, tgt_value = 0, xlate_vaddr, cache_op_vaddr;
  logic [35:0] xlate_paddr = 36'h0_abcd_1230, cache_op_paddr;
  logic [3:0]  cop_enable = 4'h6;
  logic [4:0]  cache_op_code;
  logic        xlate_req, cache_op_req, undefined, cop_float_exc;
  priv_mode_e  priv_mode = MODE_USER;
  cop_req_s    cop_req;
  gpr_wr_s     gpr_wr;
  exc_s        exc;
  int          num_errors = 0, total_checks = 0, cycles = 0;
  cop_dword_exec i_dut (.clk, .sys_rst, .instr_valid, .instr, .src_value, .tgt_value,
    .mode_64, .priv_mode, .cop_enable, .cop_rd_data, .cop_float_exc, .xlate_paddr,
    .xlate_uncached, .xlate_done, .xlate_tlb_invalid, .xlate_tlb_miss, .xlate_addr_error,
    .cache_bus_error, .cop_req, .xlate_req, .xlate_vaddr, .cache_op_req, .cache_op_code,
    .cache_op_vaddr, .cache_op_paddr, .gpr_wr, .exc, .undefined);
  cop_partner i_cop (.clk, .sys_rst, .cop_req, .fexc_cmd, .cop_rd_data, .cop_float_exc);
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic go(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b);
    @(negedge clk);
    instr = i;
    src_value = a;
    tgt_value = b;
    instr_valid = 1;
    @(negedge clk);
    instr_valid = 0;
  endtask : go
  task automatic t_adds;
    go(32'h0022_182c, 64'h7fff_ffff_ffff_ffff, 64'h1);
    chk("ovf", 1, exc.int_overflow);
    chk("ovf_wr", 0, gpr_wr.valid);
    go(32'h0022_182c, 64'hffff_ffff_ffff_fffe, 64'h3);
    chk("sum", 64'h1, gpr_wr.data);
    chk("idx", 3, gpr_wr.idx);
    go(32'h6022_ffff, 64'h8000_0000_0000_0000, 0);
    chk("i_ovf", 1, exc.int_overflow);
    chk("i_wr", 0, gpr_wr.valid);
    go(32'h6422_ffff, 64'h8000_0000_0000_0000, 0);
    chk("iu_sum", 64'h7fff_ffff_ffff_ffff, gpr_wr.data);
    chk("iu_ovf", 0, exc.int_overflow);
    chk("iu_idx", 2, gpr_wr.idx);
    go(32'h0022_182d, 64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_ffff);
    chk("u_sum", 64'hffff_ffff_ffff_fffe, gpr_wr.data);
    chk("u_ovf", 0, exc.int_overflow);
  endtask : t_adds
  task automatic t_mode;
    priv_mode_e  pm [3] = '{MODE_USER, MODE_SUPER, MODE_KERN};
    logic [31:0] op [4] = '{32'h0022_182c, 32'h0022_182d, 32'h6022_0001, 32'h6422_0001};
    mode_64 = 0;
    foreach (pm[k]) begin
      foreach (op[j]) begin
        priv_mode = pm[k];
        go(op[j], 64'h1, 64'h2);
        chk("resv", pm[k] != MODE_KERN, exc.reserved_instr);
        chk("wr", pm[k] == MODE_KERN, gpr_wr.valid);
      end
    end
    mode_64 = 1;
    priv_mode = MODE_USER;
  endtask : t_mode
  task automatic t_moves;
    go(32'h48c2_2800, 0, 64'h1234_5678_8765_4321);
    chk("ct", 32'h8765_4321, cop_req.data);
    chk("ct_sel", 5, cop_req.reg_sel);
    chk("ct_wr", 1, cop_req.write);
    chk("ct_unit", 2, cop_req.unit);
    go(32'h4842_2800, 0, 0);
    @(negedge clk);
    chk("cf64", 64'hffff_ffff_8765_4321, gpr_wr.data);
    mode_64 = 0;
    go(32'h4842_2800, 0, 0);
    @(negedge clk);
    chk("cf32", 64'h0000_0000_8765_4321, gpr_wr.data);
    mode_64 = 1;
    go(32'h4042_2800, 0, 0);
    chk("cp0", 1, undefined);
    go(32'h4c42_2800, 0, 0);
    chk("unus", 1, exc.cop_unusable);
    go(32'h4842_2801, 0, 0);
    chk("zero_fld", 1, undefined);
  endtask : t_moves
  task automatic t_op;
    fexc_cmd = 1;
    go(32'h4601_2345, 0, 0);
    chk("cofun", 25'h001_2345, cop_req.cofun);
    chk("op_wr", 0, gpr_wr.valid);
    @(negedge clk);
    chk("fexc", 1, exc.float_exc);
    fexc_cmd = 0;
  endtask : t_op
  task automatic t_cache;
    priv_mode = MODE_KERN;
    go(32'hbc35_fff0, 64'h1000, 0);
    chk("va", 64'hff0, xlate_vaddr);
    chk("xreq", 1, xlate_req);
    xlate_done = 1;
    @(negedge clk);
    xlate_done = 0;
    chk("pa", 36'h0_abcd_1230, cache_op_paddr);
    chk("code", 5'h15, cache_op_code);
    chk("c_req", 1, cache_op_req);
    chk("c_va", 64'hff0, cache_op_vaddr);
    go(32'hbc35_fff0, 64'h1000, 0);
    @(negedge clk);
    xlate_done = 1;
    xlate_tlb_miss = 1;
    xlate_tlb_invalid = 1;
    xlate_addr_error = 1;
    @(negedge clk);
    xlate_done = 0;
    xlate_tlb_miss = 0;
    xlate_tlb_invalid = 0;
    xlate_addr_error = 0;
    chk("miss", 1, exc.tlb_miss);
    chk("inv", 1, exc.tlb_invalid);
    chk("adr", 1, exc.addr_error);
    chk("no_op", 0, cache_op_req);
    cache_bus_error = 1;
    @(negedge clk);
    cache_bus_error = 0;
    chk("bus", 1, exc.bus_error);
    priv_mode = MODE_USER;
    go(32'hbc35_fff0, 64'h1000, 0);
    chk("c_unus", 1, exc.cop_unusable);
  endtask : t_cache
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 0;
    t_adds();
    t_mode();
    t_moves();
    t_op();
    t_cache();
    summarize();
  end
endmodule : tb_cop_dword_exec
